// ==== logic/bus_pin_mux.sv ====
module bus_pin_mux (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic [2:0]  mode_pin,
    input  wire logic        standby_force_n,
    input  wire logic        bus_request_in,
    input  wire logic        wait_req_n,
    input  wire logic [15:0] data_in,
    input  wire logic        int_req,
    input  wire logic        int_write,
    input  wire logic        int_hi_byte,
    input  wire logic        int_lo_byte,
    input  wire logic        int_refresh,
    input  wire logic [1:0]  int_area,
    input  wire logic [23:0] int_addr,
    input  wire logic [15:0] int_wdata,
    input  wire logic        dram_area3_en,
    input  wire logic        dual_column_strobe_dram,
    input  wire logic        sw_low_byte_wr,
    input  wire logic        sw_low_byte_bus,
    input  wire logic [7:0]  shared_low_byte_port_out,
    input  wire logic [7:0]  shared_low_byte_port_oe,
    input  wire logic [8:0]  ctl_port_out,
    input  wire logic [8:0]  ctl_port_oe,
    output logic             int_ready,
    output logic             int_ack,
    output logic [15:0]      int_rdata,
    output logic [2:0]       mode_now,
    output logic             mode_valid,
    output logic             low_byte_is_bus,
    output logic             hw_standby,
    output logic             bus_grant_ack_n,
    output logic             address_strobe_n,
    output logic             read_strobe_n,
    output logic             upper_write_strobe_n,
    output logic             lower_write_strobe_n,
    output logic [3:0]       area_select_n,
    output logic             refresh_cycle_flag,
    output logic [8:0]       ctl_pin_oe,
    output logic [23:0]      addr_out,
    output logic             addr_oe,
    output logic [15:0]      data_out,
    output logic [15:0]      data_oe
);
    typedef struct packed {
        bus_pin_pkg::bus_state_t st;
        logic [2:0]              mode;
        logic                    captured;
        logic [1:0]              cap_cnt;
        logic                    low_bus;
        logic                    ack;
        logic [15:0]             rdata;
        logic [23:0]             addr;
        logic [15:0]             wdata;
        logic                    write;
        logic                    hi;
        logic                    lo;
        logic                    refresh;
        logic [1:0]              area;
        logic                    dram;
        logic                    dual_cas;
        logic [8:0]              strobe;
    } ctl_state_t;
    ctl_state_t  st_reg;
    ctl_state_t  st_next;
    logic [2:0]  mode_sync;
    logic        standby_sync_n;
    logic        bus_request_in_sync;
    logic        wait_sync_n;
    logic [15:0] data_sync;
    logic        ext_mode;
    logic        ctl_bus_fn;
    logic        granted;
    logic        busy;
    logic [8:0]  ctl_bus_val;
    logic [15:0] data_bus_oe;
    logic [7:0]  low_pin_out;
    logic [7:0]  low_pin_oe;
    // all pins from outside pass two flops before any logic reads them
    sync2 #(.W(3)) u_sync_mode (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .async_in (mode_pin),
        .rst_val  (bus_pin_pkg::MODE_NONE),
        .sync_out (mode_sync)
    );
    sync2 #(.W(3)) u_sync_ctl (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .async_in ({standby_force_n, bus_request_in, wait_req_n}),
        .rst_val  (3'h5),
        .sync_out ({standby_sync_n, bus_request_in_sync, wait_sync_n})
    );
    sync2 #(.W(16)) u_sync_data (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .async_in (data_in),
        .rst_val  (16'h0000),
        .sync_out (data_sync)
    );
    // strobe levels for a given bus phase; DRAM in area 3 reuses the pins
    function automatic logic [8:0] strobes_of(input ctl_state_t s);
        logic [8:0] v;
        logic       act;
        logic       late;
        logic       cas;
        v    = bus_pin_pkg::STROBE_IDLE;
        act  = (s.st == bus_pin_pkg::ST_T1) || (s.st == bus_pin_pkg::ST_T2)
            || (s.st == bus_pin_pkg::ST_TW);
        late = (s.st == bus_pin_pkg::ST_T2) || (s.st == bus_pin_pkg::ST_TW);
        cas  = s.refresh ? act : late; // refresh runs column before row
        if (act) begin
            v[bus_pin_pkg::CTL_AS]   = s.refresh;
            v[bus_pin_pkg::CTL_REFRESH_CYCLE_FLAG] = s.refresh;
            if (!s.dram) begin
                if (!s.refresh) begin
                    v[bus_pin_pkg::CTL_CS0 + 32'(s.area)] = 1'b0;
                    v[bus_pin_pkg::CTL_RD]  = s.write;
                    v[bus_pin_pkg::CTL_HWR] = !(late && s.write && s.hi);
                    v[bus_pin_pkg::CTL_LWR] = !(late && s.write && s.lo);
                end
            end else begin
                v[bus_pin_pkg::CTL_CS3] = s.refresh ? !late : 1'b0;
                if (!s.dual_cas) begin
                    v[bus_pin_pkg::CTL_RD]  = !cas;
                    v[bus_pin_pkg::CTL_HWR] = !(!s.refresh && s.write && s.hi);
                    v[bus_pin_pkg::CTL_LWR] = !(!s.refresh && s.write && s.lo);
                end else begin
                    v[bus_pin_pkg::CTL_RD]  = !(!s.refresh && s.write);
                    v[bus_pin_pkg::CTL_HWR] = !(cas && (s.refresh || s.hi));
                    v[bus_pin_pkg::CTL_LWR] = !(cas && (s.refresh || s.lo));
                end
            end
        end
        return v;
    endfunction : strobes_of
    // modes 1..5 run external cycles; 6, 7 are single chip, 0 is no mode
    assign ext_mode   = st_reg.captured && (st_reg.mode != bus_pin_pkg::MODE_NONE)
                     && (st_reg.mode < bus_pin_pkg::MODE_6);
    assign ctl_bus_fn = !st_reg.captured || ext_mode;
    assign granted    = (st_reg.st == bus_pin_pkg::ST_REL);
    assign busy       = (st_reg.st == bus_pin_pkg::ST_T1) || (st_reg.st == bus_pin_pkg::ST_T2)
                     || (st_reg.st == bus_pin_pkg::ST_TW);
    assign int_ready  = ext_mode && standby_sync_n && (st_reg.st == bus_pin_pkg::ST_IDLE)
                     && !bus_request_in_sync;
    // next state: mode capture, low-byte function, bus cycle sequencer
    always_comb begin
        st_next     = st_reg;
        st_next.ack = 1'b0;
        // mode pins are a strap: taken once, after the synchronisers settle
        if (!st_reg.captured) begin
            if (st_reg.cap_cnt == bus_pin_pkg::MODE_CAP_WAIT) begin
                st_next.captured = 1'b1;
                st_next.mode     = mode_sync;
                st_next.low_bus  = (mode_sync == bus_pin_pkg::MODE_2)
                                || (mode_sync == bus_pin_pkg::MODE_4);
            end else begin
                st_next.cap_cnt = st_reg.cap_cnt + 2'h1;
            end
        end else if (sw_low_byte_wr && ext_mode) begin
            st_next.low_bus = sw_low_byte_bus;
        end
        case (st_reg.st)
            bus_pin_pkg::ST_IDLE: begin
                if (!standby_sync_n || !ext_mode) begin
                    st_next.st = bus_pin_pkg::ST_IDLE;
                end else if (bus_request_in_sync) begin
                    st_next.st = bus_pin_pkg::ST_REL;
                end else if (int_req) begin
                    st_next.st       = bus_pin_pkg::ST_T1;
                    st_next.addr     = int_addr;
                    st_next.wdata    = int_wdata;
                    st_next.write    = int_write && !int_refresh;
                    st_next.hi       = int_hi_byte;
                    st_next.lo       = int_lo_byte;
                    st_next.refresh  = int_refresh;
                    st_next.area     = int_area;
                    st_next.dram     = dram_area3_en && (int_refresh
                                    || (int_area == bus_pin_pkg::AREA_DRAM));
                    st_next.dual_cas = dual_column_strobe_dram;
                end
            end
            bus_pin_pkg::ST_T1: begin
                st_next.st = bus_pin_pkg::ST_T2;
            end
            bus_pin_pkg::ST_T2, bus_pin_pkg::ST_TW: begin
                // wait is sampled each late state; the cycle ends once it is high
                if (!wait_sync_n) begin
                    st_next.st = bus_pin_pkg::ST_TW;
                end else begin
                    st_next.st    = bus_pin_pkg::ST_IDLE;
                    st_next.ack   = 1'b1;
                    st_next.rdata = st_reg.write ? st_reg.rdata : data_sync;
                end
            end
            bus_pin_pkg::ST_REL: begin
                if (!bus_request_in_sync || !standby_sync_n) begin
                    st_next.st = bus_pin_pkg::ST_IDLE;
                end
            end
            default: begin
                st_next.st = bus_pin_pkg::ST_IDLE;
            end
        endcase
        // standby drops any cycle in flight; its strobes return to rest
        if (!standby_sync_n) begin
            st_next.st = bus_pin_pkg::ST_IDLE;
        end
        st_next.strobe = strobes_of(st_next);
    end
    // whole state in one register; reset is constants only
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_reg        <= '0;
            st_reg.st     <= bus_pin_pkg::ST_IDLE;
            st_reg.strobe <= bus_pin_pkg::STROBE_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end
    // strobes are driven in modes 1..5 and before capture, except in standby or while an outside master owns the bus
    pin_drive #(.W(9)) u_ctl_pins (
        .bus_fn   (ctl_bus_fn),
        .standby  (!standby_sync_n),
        .bus_val  (st_reg.strobe),
        .bus_oe   ({9{!granted}}),
        .port_val (ctl_port_out),
        .port_oe  (ctl_port_oe),
        .pin_out  (ctl_bus_val),
        .pin_oe   (ctl_pin_oe)
    );
    assign address_strobe_n     = ctl_bus_val[bus_pin_pkg::CTL_AS];
    assign read_strobe_n        = ctl_bus_val[bus_pin_pkg::CTL_RD];
    assign upper_write_strobe_n = ctl_bus_val[bus_pin_pkg::CTL_HWR];
    assign lower_write_strobe_n = ctl_bus_val[bus_pin_pkg::CTL_LWR];
    assign area_select_n        = ctl_bus_val[bus_pin_pkg::CTL_CS3:bus_pin_pkg::CTL_CS0];
    assign refresh_cycle_flag   = ctl_bus_val[bus_pin_pkg::CTL_REFRESH_CYCLE_FLAG];
    // write data lanes; lower lane only when the shared byte is on the bus
    assign data_bus_oe = {{8{busy && st_reg.write && st_reg.hi}},
                          {8{busy && st_reg.write && st_reg.lo}}};
    pin_drive #(.W(8)) u_low_pins (
        .bus_fn   (ext_mode && st_reg.low_bus),
        .standby  (!standby_sync_n),
        .bus_val  (st_reg.wdata[7:0]),
        .bus_oe   (data_bus_oe[7:0]),
        .port_val (shared_low_byte_port_out),
        .port_oe  (shared_low_byte_port_oe),
        .pin_out  (low_pin_out),
        .pin_oe   (low_pin_oe)
    );
    assign data_out        = {st_reg.wdata[15:8], low_pin_out};
    assign data_oe         = {(standby_sync_n && ext_mode) ? data_bus_oe[15:8] : 8'h00,
                              low_pin_oe};
    assign addr_out        = st_reg.addr;
    assign addr_oe         = ext_mode && standby_sync_n && !granted;
    assign bus_grant_ack_n = !granted;
    assign int_ack         = st_reg.ack;
    assign int_rdata       = st_reg.rdata;
    assign mode_now        = st_reg.mode;
    assign mode_valid      = st_reg.captured && (st_reg.mode != bus_pin_pkg::MODE_NONE);
    assign low_byte_is_bus = st_reg.low_bus;
    assign hw_standby      = !standby_sync_n;
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    no_mode_idle_a: assert property (
        st_reg.captured && st_reg.mode == bus_pin_pkg::MODE_NONE |-> !mode_valid && !busy)
        else $error("bus active with no valid mode");
    low_byte_reset_a: assert property (
        $rose(st_reg.captured) |-> st_reg.low_bus ==
            (st_reg.mode == bus_pin_pkg::MODE_2 || st_reg.mode == bus_pin_pkg::MODE_4))
        else $error("shared low byte wrong after reset");
    single_chip_ports_a: assert property (st_reg.captured &&
        st_reg.mode >= bus_pin_pkg::MODE_6 && !hw_standby |-> ctl_pin_oe == ctl_port_oe)
        else $error("strobe pins not ports in single chip mode");
    standby_float_a: assert property (
        !standby_sync_n |-> ctl_pin_oe == 9'h000 && data_oe == 16'h0000 && !addr_oe)
        else $error("pins driven in standby");
    grant_release_a: assert property (
        bus_request_in_sync && standby_sync_n && ext_mode && st_reg.st == bus_pin_pkg::ST_IDLE
        |=> !bus_grant_ack_n && !addr_oe && ctl_pin_oe == 9'h000)
        else $error("bus not released on request");
    addr_strobe_a: assert property (
        busy && !st_reg.refresh && ext_mode |-> !address_strobe_n)
        else $error("address strobe high during cycle");
    read_strobe_a: assert property (
        st_reg.st == bus_pin_pkg::ST_T1 && !st_reg.write && !st_reg.dram && !st_reg.refresh
        |-> !read_strobe_n && !area_select_n[st_reg.area] ##1 !read_strobe_n)
        else $error("read strobe or select missing");
    write_lanes_a: assert property (
        st_reg.st == bus_pin_pkg::ST_T2 && st_reg.write && !st_reg.dram
        |-> upper_write_strobe_n == !st_reg.hi && lower_write_strobe_n == !st_reg.lo)
        else $error("write strobe lane wrong");
    wait_insert_a: assert property (
        st_reg.st == bus_pin_pkg::ST_T2 && !wait_sync_n && standby_sync_n
        |=> st_reg.st == bus_pin_pkg::ST_TW && !int_ack)
        else $error("wait state not inserted");
    refresh_flag_a: assert property (
        busy && st_reg.refresh && ext_mode |-> refresh_cycle_flag)
        else $error("refresh flag missing");
    dram_ras_a: assert property (
        busy && st_reg.dram && !st_reg.refresh && ext_mode |-> !area_select_n[3])
        else $error("row strobe missing");
    dram_cas_a: assert property (
        st_reg.st == bus_pin_pkg::ST_T2 && st_reg.dram && !st_reg.refresh && ext_mode
        |-> (st_reg.dual_cas ? (upper_write_strobe_n == !st_reg.hi) : !read_strobe_n))
        else $error("column strobe wrong");
    strobe_rest_a: assert property (
        st_reg.st == bus_pin_pkg::ST_IDLE |-> st_reg.strobe == bus_pin_pkg::STROBE_IDLE)
        else $error("strobes not at rest");
    cycle_len_a: assert property (st_reg.st == bus_pin_pkg::ST_T1 &&
        wait_sync_n |=> ##[0:1] int_ack || !wait_sync_n || hw_standby)
        else $error("cycle did not end");
    write_cycle_c: cover property (st_reg.st == bus_pin_pkg::ST_T2 && st_reg.write);
    wait_cycle_c:  cover property (st_reg.st == bus_pin_pkg::ST_TW);
    grant_c:       cover property (granted);
    refresh_c:     cover property (busy && st_reg.refresh && st_reg.dram);
endmodule : bus_pin_mux

// ==== logic/bus_pin_pkg.sv ====
package bus_pin_pkg;
    // operating mode field and the all-zero pattern that selects nothing
    localparam int          MODE_W         = 3;
    localparam logic [2:0]  MODE_NONE      = 3'h0;
    localparam logic [2:0]  MODE_1         = 3'h1;
    localparam logic [2:0]  MODE_2         = 3'h2;
    localparam logic [2:0]  MODE_3         = 3'h3;
    localparam logic [2:0]  MODE_4         = 3'h4;
    localparam logic [2:0]  MODE_5         = 3'h5;
    localparam logic [2:0]  MODE_6         = 3'h6;
    localparam logic [2:0]  MODE_7         = 3'h7;
    // cycles after reset release before the synchronised mode pins are trusted
    localparam logic [1:0]  MODE_CAP_WAIT  = 2'h2;
    // strobe vector bit positions
    localparam int          CTL_W          = 9;
    localparam int          CTL_AS         = 0;
    localparam int          CTL_RD         = 1;
    localparam int          CTL_HWR        = 2;
    localparam int          CTL_LWR        = 3;
    localparam int          CTL_CS0        = 4;
    localparam int          CTL_CS3        = 7;
    localparam int          CTL_REFRESH_CYCLE_FLAG       = 8;
    // resting levels: every low-active strobe high, refresh flag low
    localparam logic [8:0]  STROBE_IDLE    = 9'h0ff;
    localparam logic [1:0]  AREA_DRAM      = 2'h3;
    localparam int          ADDR_W         = 24;
    localparam int          DATA_W         = 16;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_T1,
        ST_T2,
        ST_TW,
        ST_REL
    } bus_state_t;
endpackage : bus_pin_pkg

// ==== logic/pin_drive.sv ====
module pin_drive #(
    parameter int W = 1
) (
    input  wire logic         bus_fn,
    input  wire logic         standby,
    input  wire logic [W-1:0] bus_val,
    input  wire logic [W-1:0] bus_oe,
    input  wire logic [W-1:0] port_val,
    input  wire logic [W-1:0] port_oe,
    output logic      [W-1:0] pin_out,
    output logic      [W-1:0] pin_oe
);
    // a pin serves either the bus or the port; standby floats everything
    assign pin_out = bus_fn ? bus_val : port_val;
    assign pin_oe  = standby ? '0 : (bus_fn ? bus_oe : port_oe);
endmodule : pin_drive

// ==== logic/sync2.sv ====
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    input  wire logic [W-1:0] async_in,
    input  wire logic [W-1:0] rst_val,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic         init_reg;

    // rst_val is loaded by the clock after release, never by the async reset itself
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= '0;
            sync_reg <= '0;
            init_reg <= 1'b0;
        end else begin
            init_reg <= 1'b1;
            meta_reg <= async_in;
            sync_reg <= init_reg ? meta_reg : rst_val;
        end
    end

    // until the first clock after release the output shows rst_val, so a held
    // reset reads as the idle pin level instead of all zeros
    assign sync_out = init_reg ? sync_reg : rst_val;
endmodule : sync2

// ==== testbench/ext_mem_model.sv ====
module ext_mem_model (
    input  wire logic        clk_sys,
    input  wire logic        busy,
    input  wire logic        dram,
    input  wire logic [7:0]  n_wait,
    input  wire logic [23:0] rd_addr,
    input  wire logic [23:0] addr_out,
    input  wire logic [15:0] data_out,
    input  wire logic        upper_write_strobe_n,
    input  wire logic        lower_write_strobe_n,
    output logic      [15:0] data_in,
    output logic             wait_req_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [int];
    int          cnt = 0;
    // read data stands for the whole request, since the pins reach the core two edges late;
    // a released data bus toggles every cycle so a stale value can never look valid
    always @(posedge clk_sys) begin
        if (busy)
            data_in <= mem.exists(int'(rd_addr)) ? mem[int'(rd_addr)] : 16'h0000;
        else
            data_in <= ~data_in;
        cnt <= busy ? cnt + 1 : 0;
        wait_req_n <= !(busy && n_wait != 8'h00 && cnt < n_wait + 4);
        if (!dram && !upper_write_strobe_n)
            mem[int'(addr_out)][15:8] <= data_out[15:8];
        if (!dram && !lower_write_strobe_n)
            mem[int'(addr_out)][7:0] <= data_out[7:0];
    end
    initial begin
        data_in = 16'h5a5a;
        wait_req_n = 1'b1;
    end
endmodule : ext_mem_model

// ==== testbench/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    `define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
        $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
    logic clk_sys = 1'b0, nrst = 1'b0, standby_force_n = 1'b1, bus_request_in = 1'b0;
    logic int_req = 1'b0, int_write = 1'b0, int_hi_byte = 1'b0, int_lo_byte = 1'b0;
    logic int_refresh = 1'b0, dram_area3_en = 1'b0, dual_column_strobe_dram = 1'b0;
    logic sw_low_byte_wr = 1'b0, sw_low_byte_bus = 1'b0, busy = 1'b0;
    logic [1:0]  int_area = 2'h0;
    logic [2:0]  mode_pin = 3'h0, mode_now;
    logic [7:0]  shared_low_byte_port_out = 8'h00, shared_low_byte_port_oe = 8'h00;
    logic [7:0]  n_wait = 8'h00;
    logic [8:0]  ctl_port_out = 9'h000, ctl_port_oe = 9'h000, ctl_pin_oe, t1, t2;
    logic [23:0] int_addr = 24'h00_0000, addr_out, a;
    logic [15:0] int_wdata = 16'h0000, data_in, int_rdata, data_out, data_oe, d, dq;
    logic        wait_req_n, int_ready, int_ack, mode_valid, low_byte_is_bus, hw_standby;
    logic        bus_grant_ack_n, address_strobe_n, read_strobe_n, upper_write_strobe_n;
    logic        lower_write_strobe_n, refresh_cycle_flag, addr_oe, w;
    logic [3:0]  area_select_n;
    logic [1:0]  ln;
    logic [15:0] ref_mem [int];
    int          fail_count = 0, check_count = 0, cyc = 0, lat;

    bus_pin_mux uut (.clk_sys(clk_sys), .nrst(nrst), .mode_pin(mode_pin),
        .standby_force_n(standby_force_n), .bus_request_in(bus_request_in),
        .wait_req_n(wait_req_n), .data_in(data_in), .int_req(int_req), .int_write(int_write),
        .int_hi_byte(int_hi_byte), .int_lo_byte(int_lo_byte), .int_refresh(int_refresh),
        .int_area(int_area), .int_addr(int_addr), .int_wdata(int_wdata),
        .dram_area3_en(dram_area3_en), .dual_column_strobe_dram(dual_column_strobe_dram),
        .sw_low_byte_wr(sw_low_byte_wr), .sw_low_byte_bus(sw_low_byte_bus),
        .shared_low_byte_port_out(shared_low_byte_port_out),
        .shared_low_byte_port_oe(shared_low_byte_port_oe), .ctl_port_out(ctl_port_out),
        .ctl_port_oe(ctl_port_oe), .int_ready(int_ready), .int_ack(int_ack),
        .int_rdata(int_rdata), .mode_now(mode_now), .mode_valid(mode_valid),
        .low_byte_is_bus(low_byte_is_bus), .hw_standby(hw_standby),
        .bus_grant_ack_n(bus_grant_ack_n), .address_strobe_n(address_strobe_n),
        .read_strobe_n(read_strobe_n), .upper_write_strobe_n(upper_write_strobe_n),
        .lower_write_strobe_n(lower_write_strobe_n), .area_select_n(area_select_n),
        .refresh_cycle_flag(refresh_cycle_flag), .ctl_pin_oe(ctl_pin_oe),
        .addr_out(addr_out), .addr_oe(addr_oe), .data_out(data_out), .data_oe(data_oe));
    ext_mem_model far_side (.clk_sys(clk_sys), .busy(busy), .dram(dram_area3_en),
        .n_wait(n_wait), .rd_addr(int_addr), .addr_out(addr_out), .data_out(data_out),
        .upper_write_strobe_n(upper_write_strobe_n),
        .lower_write_strobe_n(lower_write_strobe_n), .data_in(data_in),
        .wait_req_n(wait_req_n));

    always #50 clk_sys = ~clk_sys;
    // a hang ends the run here rather than in the simulator's own limit
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            complete_run();
        end
    end

    function automatic logic [8:0] pins();
        return {address_strobe_n, read_strobe_n, upper_write_strobe_n, lower_write_strobe_n,
                area_select_n, refresh_cycle_flag};
    endfunction : pins

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    // mode pins only change while the chip is held in reset
    task automatic do_reset(input logic [2:0] m);
        @(negedge clk_sys);
        nrst = 1'b0;
        mode_pin = m;
        ctl_port_out = 9'($urandom);
        ctl_port_oe = 9'($urandom);
        repeat (10) @(negedge clk_sys);
        `CHK("idle", 9'h1fe, pins())
        `CHK("idle_oe", 9'h1ff, ctl_pin_oe)
        nrst = 1'b1;
        repeat (6) @(negedge clk_sys);
    endtask : do_reset

    // one internal request; t1 and t2 hold the strobes of the first two states
    task automatic xfer(input logic wr, input logic [1:0] lanes, input logic rf,
                        input logic [1:0] ar, input logic [23:0] ad, input logic [15:0] dt);
        int t;
        @(negedge clk_sys);
        busy = 1'b1;
        // address leads the request: read data needs two edges through the synchroniser
        {int_write, int_hi_byte, int_lo_byte, int_refresh, int_area} = {wr, lanes, rf, ar};
        int_addr = ad;
        int_wdata = dt;
        repeat (2) @(negedge clk_sys);
        int_req = 1'b1;
        for (t = 0; t < 20 && int_ready !== 1'b1; t++) @(negedge clk_sys);
        @(negedge clk_sys);
        t1 = pins();
        @(negedge clk_sys);
        t2 = pins();
        dq = data_oe;
        for (lat = 2; lat < 30 && int_ack !== 1'b1; lat++) @(negedge clk_sys);
        `CHK("ack", 1'b1, int_ack)
        int_req = 1'b0;
        busy = 1'b0;
    endtask : xfer

    initial begin
        void'($urandom(32'h3390_bdb6));
        for (int m = 0; m < 8; m++) begin
            do_reset(m[2:0]);
            `CHK("mode", m[2:0], mode_now)
            `CHK("valid", m != 0, mode_valid)
            `CHK("lowbus", m == 2 || m == 4, low_byte_is_bus)
            `CHK("ready", m inside {[1:5]}, int_ready)
            if (m >= 6) `CHK("port_oe", ctl_port_oe[8:2], ctl_pin_oe[8:2])
            if (m >= 6) `CHK("port_sel", ctl_port_out[7:4], area_select_n)
            if (m inside {[1:5]}) begin
                sw_low_byte_bus = !(m == 2 || m == 4);
                sw_low_byte_wr = 1'b1;
                @(negedge clk_sys);
                sw_low_byte_wr = 1'b0;
                repeat (2) @(negedge clk_sys);
                `CHK("sw_low", sw_low_byte_bus, low_byte_is_bus)
            end
        end
        do_reset(3'h2);
        for (int i = 0; i < 24; i++) begin
            a = 24'h00_0100 + 24'((i % 4) * 2);
            d = 16'($urandom);
            w = (i < 4) || ($urandom_range(1, 0) == 1);
            ln = (i < 4) ? 2'b11 : 2'($urandom_range(3, 1));
            n_wait = (i % 3 == 1) ? 8'h03 : 8'h00;
            xfer(w, ln, 1'b0, 2'(i), a, d);
            `CHK("as_t1", 1'b0, t1[8])
            `CHK("cs_t1", ~(4'h1 << (i % 4)), t1[4:1])
            `CHK("rd_t1", w, t1[7])
            `CHK("hwr_t2", !(w && ln[1]), t2[6])
            `CHK("lwr_t2", !(w && ln[0]), t2[5])
            `CHK("data_oe", {{8{w && ln[1]}}, {8{w && ln[0]}}}, dq)
            `CHK("wait", n_wait != 8'h00, lat > 3)
            if (w && ln[1]) ref_mem[int'(a)][15:8] = d[15:8];
            if (w && ln[0]) ref_mem[int'(a)][7:0] = d[7:0];
            if (!w) `CHK("rdata", ref_mem[int'(a)], int_rdata)
        end
        n_wait = 8'h00;
        xfer(1'b0, 2'b11, 1'b1, 2'h0, 24'h00_0000, 16'h0000);
        `CHK("refresh", 2'b11, {t1[0], t1[8]})
        dram_area3_en = 1'b1;
        for (int k = 0; k < 2; k++) begin
            dual_column_strobe_dram = k[0];
            xfer(1'b1, 2'b10, 1'b0, 2'h3, 24'h00_0200, 16'h1234);
            `CHK("ras", 1'b0, t1[4])
            if (k == 0) `CHK("we_up", 2'b01, t1[6:5])
            if (k == 1) `CHK("rd_we", 1'b0, t1[7])
            if (k == 1) `CHK("cas_up", 2'b01, t2[6:5])
            xfer(1'b0, 2'b11, 1'b0, 2'h3, 24'h00_0200, 16'h0000);
            if (k == 0) `CHK("rd_cas", 1'b0, t2[7])
        end
        dram_area3_en = 1'b0;
        bus_request_in = 1'b1;
        for (int t = 0; t < 10 && bus_grant_ack_n !== 1'b0; t++) @(negedge clk_sys);
        `CHK("grant", 12'h000, {bus_grant_ack_n, ctl_pin_oe, int_ready, addr_oe})
        bus_request_in = 1'b0;
        for (int t = 0; t < 10 && bus_grant_ack_n !== 1'b1; t++) @(negedge clk_sys);
        `CHK("regain", 1'b1, bus_grant_ack_n)
        standby_force_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        `CHK("standby", 10'h200, {hw_standby, ctl_pin_oe})
        standby_force_n = 1'b1;
        do_reset(3'h4);
        `CHK("after_rst", 3'h4, mode_now)
        complete_run();
    end
endmodule : testbench
